// file: src/sfr_map.svh
// Constants of the serial flash read path: opcodes, field positions, page and buffer sizes.
// Included by the design files and the testbench; definitions only.
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH

// Read opcodes
`define SFR_OP_LEGACY    8'hE8
`define SFR_OP_FAST      8'h0B
`define SFR_OP_SLOW      8'h03
`define SFR_OP_PAGE      8'hD2
`define SFR_OP_BUF1_FAST 8'hD4
`define SFR_OP_BUF1_SLOW 8'hD1
`define SFR_OP_BUF2_FAST 8'hD6
`define SFR_OP_BUF2_SLOW 8'hD3

// Index of the last header bit (opcode, address, don't-care bytes), counted from zero
`define SFR_HDR_END_NONE  7'h1F
`define SFR_HDR_END_ONE   7'h27
`define SFR_HDR_END_FOUR  7'h3F
`define SFR_HDR_END_BAD   7'h7F
`define SFR_OPCODE_LAST   7'h07
`define SFR_ADDR_FIRST    7'h08

// Address field positions inside the 24-bit address
`define SFR_PG264_LSB 9
`define SFR_PG256_LSB 8
`define SFR_PAGE_W    12
`define SFR_OFF_W     9
`define SFR_ADDR_W    21

// Page and buffer geometry
`define SFR_LAST_264  9'h107
`define SFR_LAST_256  9'h0FF
`define SFR_PAGE_MAX  12'hFFF
`define SFR_BUF_DEPTH 528
`define SFR_BUF2_BASE 10'h108

`endif

// file: src/sfr_pkg.sv
// Types shared by the serial flash read path.
// Constants live in sfr_map.svh; this package holds only types.
package sfr_pkg;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_HOLD  = 3'b100
  } sfr_state_t;

  typedef enum logic [1:0]
  {
    KIND_CONT = 2'h0,
    KIND_PAGE = 2'h1,
    KIND_BUF  = 2'h2
  } sfr_kind_t;

endpackage : sfr_pkg

// file: src/sfr_mem_if.sv
// Read and fill port between the read controller and the buffer memory.
// Everything on it runs on the system clock.
`timescale 1ns/1ps
interface sfr_mem_if;
  logic       rd;
  logic       rsel;
  logic [8:0] roff;
  logic [7:0] rdata;
  logic       rvalid;
  logic       we;
  logic       wsel;
  logic [8:0] woff;
  logic [7:0] wdata;

  modport ctrl (output rd, rsel, roff, we, wsel, woff, wdata, input rdata, rvalid);
  modport mem  (input rd, rsel, roff, we, wsel, woff, wdata, output rdata, rvalid);
endinterface : sfr_mem_if

// file: src/sfr_buffer_mem.sv
// The two data buffers held in one memory, with a registered read port.
// Assumes the system clock and reset; read data appear one clock after rd.
`timescale 1ns/1ps
`include "sfr_map.svh"
module sfr_buffer_mem
(
  // System
  input wire logic clock,
  input wire logic rst_n,
  // Controller side
  sfr_mem_if.mem   port
);

  logic [7:0] store [0:`SFR_BUF_DEPTH-1];
  logic [7:0] rdata;
  logic       rvalid;

  // Buffer 2 sits right above buffer 1
  function automatic logic [9:0] bufIndex(input logic sel, input logic [8:0] off);
    bufIndex = sel ? ({1'b0, off} + `SFR_BUF2_BASE) : {1'b0, off};
  endfunction : bufIndex

  wire [9:0] wIdx = bufIndex(port.wsel, port.woff);
  wire [9:0] rIdx = bufIndex(port.rsel, port.roff);

  always_ff @(posedge clock)
  begin
    if (port.we)
      store[wIdx] <= port.wdata;
    if (port.rd)
      rdata <= store[rIdx];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rvalid <= 1'b0;
    else
      rvalid <= port.rd;
  end

  assign port.rdata  = rdata;
  assign port.rvalid = rvalid;

endmodule : sfr_buffer_mem

// file: src/sfr_read_ctrl.sv
// Device-side read command engine of a serial flash: continuous, page and buffer reads.
// Assumes sck stands still outside frames and is far slower than clock, so that a
// fetched byte is settled in byteWord well before the falling edge that loads it.
//
// Behaviour
// - Both serial clock modes 0 and 3 are accepted for every read command.
// - Legacy continuous read: opcode E8, three address bytes, four don't-care bytes.
// - 264-byte pages: 12-bit page number then 9-bit byte offset.
// - 256-byte pages: 12-bit page number in upper bits, 8-bit offset below.
// - Continuous reads step the internal address by themselves as data is clocked.
// - The end of a page runs on into the next page without added clocks.
// - After the last array byte a continuous read wraps to page zero.
// - Chip select rising ends any read and floats the serial output.
// - Array and page reads fetch from the array; buffers stay untouched.
// - Fast continuous read: opcode 0B, three address bytes, one dummy byte.
// - Slow continuous read: opcode 03, three address bytes, data follows at once.
// - Page read: opcode D2, three address bytes, four don't-care bytes.
// - A page read wraps to the start of the same page.
// - D4 or D1 select buffer 1; D6 or D3 select buffer 2.
// - 264-byte buffer reads take a 9-bit offset, upper 15 bits ignored.
// - 256-byte buffer reads take an 8-bit offset, upper 16 bits ignored.
// - Buffer reads take one don't-care byte before data.
// - A buffer read wraps from the last buffer byte to the first.
// - A command starts at chip select falling with an 8-bit opcode.
// - Opcode, address and data travel most significant bit first.
// - Serial output changes on the falling edge of the serial clock.
`timescale 1ns/1ps
`include "sfr_map.svh"
module sfr_read_ctrl
(
  // System
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Serial link
  input  wire logic        sck,
  input  wire logic        csN,
  input  wire logic        si,
  output logic             so,
  output logic             soOe,
  // Page size setting, high for 256-byte pages
  input  wire logic        pageSize256,
  // Main array read port
  output logic             arrayRd,
  output logic [20:0]      arrayAddr,
  input  wire logic [7:0]  arrayRdata,
  input  wire logic        arrayRvalid,
  // Buffer fill port
  input  wire logic        bufWrEn,
  input  wire logic        bufWrSel,
  input  wire logic [8:0]  bufWrOff,
  input  wire logic [7:0]  bufWrData
);

  // ---------------------------------------------------------------- link domain
  // Frame logic is held in reset whenever chip select is high
  wire linkRstN = rst_n & ~csN;

  logic [6:0]  hdrCnt;
  logic [7:0]  opSh;
  logic [23:0] addrSh;
  logic        dataPhase;
  logic [31:0] launchWord;
  logic        startTgl;
  logic [2:0]  bitPos;
  logic [6:0]  shiftOut;
  logic        nextTgl;
  logic [7:0]  byteWord;

  function automatic logic [6:0] hdrEnd(input logic [7:0] op);
    case (op)
      `SFR_OP_LEGACY, `SFR_OP_PAGE:          hdrEnd = `SFR_HDR_END_FOUR;
      `SFR_OP_FAST, `SFR_OP_BUF1_FAST, `SFR_OP_BUF1_SLOW,
      `SFR_OP_BUF2_FAST, `SFR_OP_BUF2_SLOW:  hdrEnd = `SFR_HDR_END_ONE;
      `SFR_OP_SLOW:                          hdrEnd = `SFR_HDR_END_NONE;
      default:                               hdrEnd = `SFR_HDR_END_BAD;
    endcase
  endfunction : hdrEnd

  // Unknown opcodes never reach the data phase, so the output stays floating
  wire       opKnown  = hdrEnd(opSh) != `SFR_HDR_END_BAD;
  wire       lastHdr  = !dataPhase && opKnown && (hdrCnt == hdrEnd(opSh));
  wire       addrBit  = (hdrCnt >= `SFR_ADDR_FIRST) && (hdrCnt <= `SFR_HDR_END_NONE);
  wire [23:0] next_addrSh = {addrSh[22:0], si};
  // With no don't-care bytes the last address bit is the one arriving now
  wire [23:0] launchAddr  = (hdrCnt == `SFR_HDR_END_NONE) ? next_addrSh : addrSh;

  // Input sampled on the rising edge in both modes
  always_ff @(posedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      hdrCnt    <= 7'h00;
      opSh      <= 8'h00;
      addrSh    <= 24'h000000;
      dataPhase <= 1'b0;
    end
    else
    begin
      if (!dataPhase && hdrCnt != `SFR_HDR_END_BAD)
        hdrCnt <= hdrCnt + 7'h01;
      if (hdrCnt <= `SFR_OPCODE_LAST)
        opSh <= {opSh[6:0], si};
      if (addrBit)
        addrSh <= next_addrSh;
      if (lastHdr)
        dataPhase <= 1'b1;
    end
  end

  // Launch word and toggle survive chip select so that the crossing keeps its parity
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      launchWord <= 32'h00000000;
      startTgl   <= 1'b0;
    end
    else if (lastHdr)
    begin
      launchWord <= {opSh, launchAddr};
      startTgl   <= ~startTgl;
    end
  end

  // A mode 3 frame opens with a falling edge; it finds no data phase and does nothing
  always_ff @(negedge sck or negedge linkRstN)
  begin
    if (!linkRstN)
    begin
      bitPos   <= 3'h0;
      shiftOut <= 7'h00;
      so       <= 1'b0;
      soOe     <= 1'b0;
    end
    else if (dataPhase)
    begin
      soOe   <= 1'b1;
      bitPos <= bitPos + 3'h1;
      if (bitPos == 3'h0)
      begin
        so       <= byteWord[7];
        shiftOut <= byteWord[6:0];
      end
      else
      begin
        so       <= shiftOut[6];
        shiftOut <= {shiftOut[5:0], 1'b0};
      end
    end
  end

  // Each loaded byte asks for the one after it, a whole byte time ahead
  always_ff @(negedge sck or negedge rst_n)
  begin
    if (!rst_n)
      nextTgl <= 1'b0;
    else if (dataPhase && bitPos == 3'h0)
      nextTgl <= ~nextTgl;
  end

  // -------------------------------------------------------------- system domain
  logic [2:0]          startSync;
  logic [2:0]          nextSync;
  sfr_pkg::sfr_state_t state;
  sfr_pkg::sfr_kind_t  kind;
  logic                bufSel;
  logic [11:0]         page;
  logic [8:0]          offset;
  logic                memRd;
  logic [20:0]         rdAddr;
  logic                rdSel;

  sfr_mem_if memPort ();

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startSync <= 3'h0;
      nextSync  <= 3'h0;
    end
    else
    begin
      startSync <= {startSync[1:0], startTgl};
      nextSync  <= {nextSync[1:0], nextTgl};
    end
  end

  wire startEv = startSync[2] ^ startSync[1];
  wire nextEv  = nextSync[2] ^ nextSync[1];

  // Launch word is stable from the toggle until the next frame's header ends
  wire [7:0]  op     = launchWord[31:24];
  wire        isCont = (op == `SFR_OP_LEGACY) || (op == `SFR_OP_FAST) || (op == `SFR_OP_SLOW);
  wire        isPage = op == `SFR_OP_PAGE;
  wire        isBuf1 = (op == `SFR_OP_BUF1_FAST) || (op == `SFR_OP_BUF1_SLOW);
  wire        isBuf2 = (op == `SFR_OP_BUF2_FAST) || (op == `SFR_OP_BUF2_SLOW);
  wire [11:0] startPage = pageSize256 ? launchWord[`SFR_PG256_LSB +: `SFR_PAGE_W]
                                      : launchWord[`SFR_PG264_LSB +: `SFR_PAGE_W];
  // Buffer reads reuse the offset field; the page bits above are ignored
  wire [8:0]  startOff  = pageSize256 ? {1'b0, launchWord[7:0]}
                                      : launchWord[8:0];
  wire [8:0]  lastOff   = pageSize256 ? `SFR_LAST_256 : `SFR_LAST_264;
  wire        rdValid   = (kind == sfr_pkg::KIND_BUF) ? memPort.rvalid : arrayRvalid;
  wire [7:0]  rdData    = (kind == sfr_pkg::KIND_BUF) ? memPort.rdata : arrayRdata;
  wire        startGo   = startEv && (isCont || isPage || isBuf1 || isBuf2);
  wire        holdGo    = (state == sfr_pkg::ST_HOLD) && nextEv;
  wire        fetchDone = (state == sfr_pkg::ST_FETCH) && rdValid;
  wire sfr_pkg::sfr_kind_t next_kind = isBuf1 || isBuf2 ? sfr_pkg::KIND_BUF
                                     : isPage ? sfr_pkg::KIND_PAGE : sfr_pkg::KIND_CONT;

  function automatic logic [20:0] advance(input sfr_pkg::sfr_kind_t k,
                                          input logic [11:0] pg,
                                          input logic [8:0] off,
                                          input logic [8:0] last);
    if (off != last)
      advance = {pg, off + 9'h001};
    else if (k == sfr_pkg::KIND_CONT)
      advance = {pg + 12'h001, 9'h000};
    else
      advance = {pg, 9'h000};
  endfunction : advance

  wire [20:0] next_addr = advance(kind, page, offset, lastOff);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= sfr_pkg::ST_IDLE;
      kind     <= sfr_pkg::KIND_CONT;
      bufSel   <= 1'b0;
      page     <= 12'h000;
      offset   <= 9'h000;
      byteWord <= 8'h00;
    end
    else if (startGo)
    begin
      state  <= sfr_pkg::ST_FETCH;
      kind   <= next_kind;
      bufSel <= isBuf2;
      page   <= startPage;
      offset <= startOff;
    end
    else
    begin
      case (state)
        sfr_pkg::ST_FETCH:
          if (rdValid)
          begin
            byteWord       <= rdData;
            {page, offset} <= next_addr;
            state          <= sfr_pkg::ST_HOLD;
          end
        sfr_pkg::ST_HOLD:
          if (nextEv)
            state <= sfr_pkg::ST_FETCH;
        default:
          state <= sfr_pkg::ST_IDLE;
      endcase
    end
  end

  // Read strobes; array reads never touch the buffer port
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arrayRd <= 1'b0;
      memRd   <= 1'b0;
      rdAddr  <= 21'h000000;
      rdSel   <= 1'b0;
    end
    else
    begin
      arrayRd <= startGo ? !(isBuf1 || isBuf2) : holdGo && kind != sfr_pkg::KIND_BUF;
      memRd   <= startGo ? (isBuf1 || isBuf2) : holdGo && kind == sfr_pkg::KIND_BUF;
      rdAddr  <= startGo ? {startPage, startOff} : {page, offset};
      rdSel   <= startGo ? isBuf2 : bufSel;
    end
  end

  assign arrayAddr     = rdAddr;
  assign memPort.rd    = memRd;
  assign memPort.rsel  = rdSel;
  assign memPort.roff  = rdAddr[8:0];
  assign memPort.we    = bufWrEn;
  assign memPort.wsel  = bufWrSel;
  assign memPort.woff  = bufWrOff;
  assign memPort.wdata = bufWrData;

  sfr_buffer_mem u_buffers
  (
    .clock (clock),
    .rst_n (rst_n),
    .port  (memPort.mem)
  );

  // ------------------------------------------------------------------ checks
  page_cross_a: assert property (@(posedge clock) disable iff (!rst_n)
    fetchDone && kind == sfr_pkg::KIND_CONT && offset == lastOff && page != `SFR_PAGE_MAX
    |=> offset == 9'h000 && page == $past(page) + 12'h001)
    else $error("continuous read did not enter the next page");

  array_wrap_a: assert property (@(posedge clock) disable iff (!rst_n)
    fetchDone && kind == sfr_pkg::KIND_CONT && offset == lastOff && page == `SFR_PAGE_MAX
    |=> page == 12'h000 && offset == 9'h000)
    else $error("continuous read did not wrap to page zero");

  page_loop_a: assert property (@(posedge clock) disable iff (!rst_n)
    fetchDone && kind == sfr_pkg::KIND_PAGE && offset == lastOff
    |=> offset == 9'h000 && page == $past(page))
    else $error("page read left its page");

  buffer_loop_a: assert property (@(posedge clock) disable iff (!rst_n)
    fetchDone && kind == sfr_pkg::KIND_BUF && offset == lastOff |=> offset == 9'h000)
    else $error("buffer read did not wrap");

  split_264_a: assert property (@(posedge clock) disable iff (!rst_n)
    startGo && !pageSize256 && !(isBuf1 || isBuf2)
    |=> page == $past(launchWord[20:9]) && offset == $past(launchWord[8:0]))
    else $error("264-byte address split wrong");

  split_256_a: assert property (@(posedge clock) disable iff (!rst_n)
    startGo && pageSize256 && !(isBuf1 || isBuf2)
    |=> page == $past(launchWord[19:8]) && offset == {1'b0, $past(launchWord[7:0])})
    else $error("256-byte address split wrong");

  buffer_pick_a: assert property (@(posedge clock) disable iff (!rst_n)
    startEv && (isBuf1 || isBuf2) |=> kind == sfr_pkg::KIND_BUF && bufSel == $past(isBuf2))
    else $error("buffer selection wrong");

  array_only_a: assert property (@(posedge clock) disable iff (!rst_n)
    state != sfr_pkg::ST_IDLE && kind != sfr_pkg::KIND_BUF && !startGo ##1 !startGo
    |-> !memRd)
    else $error("array read touched the buffers");

  slow_header_a: assert property (@(posedge sck) disable iff (!linkRstN)
    !dataPhase && opSh == `SFR_OP_SLOW && hdrCnt == 7'h1F |=> dataPhase)
    else $error("slow read data phase not after 32 bits");

  fast_header_a: assert property (@(posedge sck) disable iff (!linkRstN)
    opSh == `SFR_OP_FAST && hdrCnt == 7'h26 |=> !dataPhase ##1 dataPhase)
    else $error("fast read dummy byte length wrong");

  long_header_a: assert property (@(posedge sck) disable iff (!linkRstN)
    (opSh == `SFR_OP_LEGACY || opSh == `SFR_OP_PAGE) && hdrCnt == 7'h3E
    |=> !dataPhase ##1 dataPhase)
    else $error("four don't-care bytes not honoured");

endmodule : sfr_read_ctrl

// file: tb/sfr_host_model.sv
// Host side of the serial link: frames a read command and collects returned bytes.
// Assumes the device shifts out on sck falling edges; bytes are sampled on rising edges.
`timescale 1ns/1ps
module sfr_host_model
(
  // Serial link
  output logic      sck,
  output logic      csN,
  output logic      si,
  input  wire logic so,
  input  wire logic soOe
);
  logic [7:0] rx[$];
  logic       sawOe;

  initial
  begin
    sck   = 1'b0;
    csN   = 1'b1;
    si    = 1'b0;
    sawOe = 1'b0;
  end

  always @(posedge soOe) sawOe = 1'b1;

  // One command per frame; sck stands still outside it, high for mode 3
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nDummy,
                       input int nData, input logic mode3);
    logic [31:0] hdr;
    logic [7:0]  b;
    int          nHdr;
    hdr = {op, addr};
    nHdr = 32 + nDummy * 8;
    rx.delete();
    sawOe = 1'b0;
    b = 8'h00;
    sck = mode3;
    #83 csN = 1'b0;
    #80;
    for (int i = 0; i < nHdr + nData * 8; i++)
    begin
      sck = 1'b0;
      // Don't-care bits toggle so the device cannot lean on a fixed level
      si = (i < 32) ? hdr[31 - i] : i[0];
      #80 sck = 1'b1;
      if (i >= nHdr)
      begin
        // A floating output reads as the inverse, so a missing enable shows up
        b = {b[6:0], soOe ? so : ~so};
        if ((i - nHdr) % 8 == 7)
          rx.push_back(b);
      end
      #80;
    end
    if (!mode3)
      sck = 1'b0;
    #40 csN = 1'b1;
    si = ~si;
    #100;
  endtask : frame
endmodule : sfr_host_model

// file: tb/tb_top.sv
// Self-checking bench of the read engine: host model on the link, array and buffer
// contents made up here. Assumes the engine answers within half an sck period.
`timescale 1ns/1ps
`include "sfr_map.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin numErrors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
  logic        clock;
  logic        rst_n;
  logic        sck;
  logic        csN;
  logic        si;
  logic        so;
  logic        soOe;
  logic        pageSize256;
  logic        arrayRd;
  logic [20:0] arrayAddr;
  logic [7:0]  arrayRdata;
  logic        arrayRvalid;
  logic        bufWrEn;
  logic        bufWrSel;
  logic [8:0]  bufWrOff;
  logic [7:0]  bufWrData;
  logic [1:0]  rdPipe;
  int          numErrors;
  int          checks;

  sfr_read_ctrl sfr_read_ctrl_inst (.clock(clock), .rst_n(rst_n), .sck(sck), .csN(csN),
    .si(si), .so(so), .soOe(soOe), .pageSize256(pageSize256), .arrayRd(arrayRd),
    .arrayAddr(arrayAddr), .arrayRdata(arrayRdata), .arrayRvalid(arrayRvalid),
    .bufWrEn(bufWrEn), .bufWrSel(bufWrSel), .bufWrOff(bufWrOff), .bufWrData(bufWrData));

  sfr_host_model sfr_host_model_inst (.sck(sck), .csN(csN), .si(si), .so(so), .soOe(soOe));

  function automatic logic [7:0] arrVal(input logic [11:0] pg, input logic [8:0] off);
    return off[7:0] ^ {pg[3:0], pg[7:4]} ^ {pg[11:8], 3'h0, off[8]};
  endfunction : arrVal

  function automatic logic [7:0] bufVal(input logic sel, input logic [8:0] off);
    return off[7:0] ^ (sel ? 8'hA5 : 8'h5A) ^ {7'h00, off[8]};
  endfunction : bufVal

  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Array answers two clocks late; between answers the data lines keep moving
  always @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      rdPipe      <= 2'h0;
      arrayRvalid <= 1'b0;
      arrayRdata  <= 8'h00;
    end
    else
    begin
      rdPipe      <= {rdPipe[0], arrayRd};
      arrayRvalid <= rdPipe[0];
      arrayRdata  <= rdPipe[0] ? arrVal(arrayAddr[20:9], arrayAddr[8:0]) : ~arrayRdata;
    end

  task automatic endOfTest();
    $display("checks=%0d mismatches=%0d", checks, numErrors);
    if (numErrors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : endOfTest

  task automatic cmpRx(input logic [7:0] exp[$]);
    `CHK(sfr_host_model_inst.rx.size(), exp.size())
    foreach (exp[i]) `CHK(sfr_host_model_inst.rx[i], exp[i])
    `CHK(soOe, 1'b0)
  endtask : cmpRx

  task automatic fillBuf(input logic sel, input logic [8:0] off);
    @(posedge clock);
    #1 bufWrEn = 1'b1;
    bufWrSel  = sel;
    bufWrOff  = off;
    bufWrData = bufVal(sel, off);
    @(posedge clock);
    #1 bufWrEn = 1'b0;
  endtask : fillBuf

  // Page size changes only between frames, just after a clock edge
  task automatic setSize(input logic v);
    @(posedge clock);
    #1 pageSize256 = v;
  endtask : setSize

  task automatic testContinuous();
    logic [7:0] ops[3] = '{`SFR_OP_LEGACY, `SFR_OP_FAST, `SFR_OP_SLOW};
    int         dum[3] = '{4, 1, 0};
    setSize(1'b0);
    foreach (ops[i])
    begin
      sfr_host_model_inst.frame(ops[i], {3'h0, 12'h005, 9'h106}, dum[i], 3, i[0]);
      cmpRx('{arrVal(12'h005, 9'h106), arrVal(12'h005, 9'h107), arrVal(12'h006, 9'h000)});
    end
    $display("testContinuous done mismatches=%0d", numErrors);
  endtask : testContinuous

  task automatic testArrayWrap();
    setSize(1'b1);
    sfr_host_model_inst.frame(`SFR_OP_FAST, {4'h0, 12'hFFF, 8'hFE}, 1, 3, 1'b1);
    cmpRx('{arrVal(12'hFFF, 9'h0FE), arrVal(12'hFFF, 9'h0FF), arrVal(12'h000, 9'h000)});
    $display("testArrayWrap done mismatches=%0d", numErrors);
  endtask : testArrayWrap

  task automatic testPageRead();
    setSize(1'b0);
    sfr_host_model_inst.frame(`SFR_OP_PAGE, {3'h0, 12'h007, 9'h107}, 4, 3, 1'b0);
    cmpRx('{arrVal(12'h007, 9'h107), arrVal(12'h007, 9'h000), arrVal(12'h007, 9'h001)});
    setSize(1'b1);
    sfr_host_model_inst.frame(`SFR_OP_PAGE, {4'h0, 12'h009, 8'hFF}, 4, 2, 1'b1);
    cmpRx('{arrVal(12'h009, 9'h0FF), arrVal(12'h009, 9'h000)});
    $display("testPageRead done mismatches=%0d", numErrors);
  endtask : testPageRead

  task automatic testBufferRead();
    logic [7:0] ops[4] = '{`SFR_OP_BUF1_FAST, `SFR_OP_BUF1_SLOW, `SFR_OP_BUF2_FAST,
                           `SFR_OP_BUF2_SLOW};
    logic       sel[4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    setSize(1'b0);
    // Upper address bits set high: the device must ignore them
    foreach (ops[i])
    begin
      sfr_host_model_inst.frame(ops[i], {15'h7FFF, 9'h107}, 1, 2, i[0]);
      cmpRx('{bufVal(sel[i], 9'h107), bufVal(sel[i], 9'h000)});
    end
    setSize(1'b1);
    sfr_host_model_inst.frame(`SFR_OP_BUF2_SLOW, {16'hFFFF, 8'hFF}, 1, 2, 1'b0);
    cmpRx('{bufVal(1'b1, 9'h0FF), bufVal(1'b1, 9'h000)});
    $display("testBufferRead done mismatches=%0d", numErrors);
  endtask : testBufferRead

  task automatic testUnknownOp();
    setSize(1'b0);
    sfr_host_model_inst.frame(8'h55, 24'h000000, 1, 1, 1'b0);
    `CHK(sfr_host_model_inst.sawOe, 1'b0)
    $display("testUnknownOp done mismatches=%0d", numErrors);
  endtask : testUnknownOp

  initial
  begin
    rst_n       = 1'b0;
    pageSize256 = 1'b0;
    bufWrEn     = 1'b0;
    bufWrSel    = 1'b0;
    bufWrOff    = 9'h000;
    bufWrData   = 8'h00;
    numErrors   = 0;
    checks      = 0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clock);
    for (int s = 0; s < 2; s++)
    begin
      fillBuf(s[0], 9'h000);
      fillBuf(s[0], 9'h0FF);
      fillBuf(s[0], 9'h107);
    end
    testContinuous();
    testArrayWrap();
    testPageRead();
    testBufferRead();
    testUnknownOp();
    endOfTest();
  end

  // About 12 frames of under 15 us each; allow generous margin
  initial
  begin
    #380000;
    numErrors++;
    endOfTest();
  end
endmodule : tb_top
